// ===== acr_pkg.sv
// constants for the algorithm clock and reset controller
// assumes clk_sys stands for the undivided core clock of the manager
package acr_pkg;
  // ---------------------------------------------
  // clocking
  // ---------------------------------------------
  localparam int CORE_MHZ = 200;
  localparam int SYS_PERIOD_PS = 10000;
  localparam int GRP_SHIFT_PS = 250;
  localparam int NUM_GRP = 4;
  localparam int CORE_PERIOD_PS = 1000000 / CORE_MHZ;
  localparam int SRAM_TX_LEAD_PS = CORE_PERIOD_PS / 4;
  localparam int PHASE_W = 12;
  // ---------------------------------------------
  // resets
  // ---------------------------------------------
  localparam int ALG_RST_CYCLES = 4;
  localparam int CORE_RST_HOLD = 8;
  localparam int NUM_MGR = 2;
  // ---------------------------------------------
  // register port
  // ---------------------------------------------
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam logic [7:0] CONTROL_OFS = 8'h00;
  localparam logic [7:0] STATUS_OFS = 8'h04;
  localparam logic [7:0] BUILD_OFS = 8'h08;
  localparam int CTRL_GO_BIT = 0;
  localparam int ST_ALGRST_BIT = 0;
  localparam int ST_CLKEN_BIT = 1;
  localparam int ST_CORERST_BIT = 2;
  localparam int ST_LOCKED_BIT = 3;
  localparam int ST_PEND_BIT = 4;
  localparam int ST_STATE_LSB = 8;
  localparam int BLD_DIV_LSB = 0;
  localparam int BLD_SRAM_LSB = 8;
  // ---------------------------------------------
  // controller states
  // ---------------------------------------------
  typedef enum logic [1:0] {
    ACR_HOLD,
    ACR_PULSE,
    ACR_RUN,
    ACR_DONE
  } acr_state_e;
endpackage : acr_pkg

// ===== acr_alg_clock_reset.sv
// algorithm clock, core reset and algorithm reset controller
// assumes clk_sys is the core clock; lock inputs come from outside
//
// Contract
// - alg clock full rate or divided, aligned
// - alg rising edges land on core edges
// - core clock fixed, manager undivided output
// - build choice selects undivided or divided
// - alg clock gated while block inactive
// - signals to alg change on alg edges
// - four data group clocks, 250 ps apart
// - sram tx clock leads core by quarter
// - primary reset resets managers asynchronously
// - chip reset on primary reset or unlock
// - core reset synchronous to core clock
// - alg reset synchronous to alg clock
// - alg reset held until first go
// - each go: alg reset four alg cycles
// - sram ports enabled by build options
`timescale 1ns/1ps
module acr_alg_clock_reset #(
  parameter int ALG_DIV = 1,
  parameter int CORE_HOLD = acr_pkg::CORE_RST_HOLD,
  parameter int NMGR = acr_pkg::NUM_MGR,
  parameter logic [1:0] SRAM_RD_EN = 2'h1,
  parameter logic [1:0] SRAM_WR_EN = 2'h2
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [NMGR-1:0] mgrLocked,
  input wire logic algDone,
  input wire logic [acr_pkg::ADDR_W-1:0] regAddr,
  input wire logic [acr_pkg::DATA_W-1:0] regWrData,
  input wire logic regWrStb,
  input wire logic regRdStb,
  output logic [acr_pkg::DATA_W-1:0] regRdData,
  output logic mgrReset,
  output logic chipRst,
  output logic coreRst,
  output logic algClkEnable,
  output logic algClkTick,
  output logic algUseDivided,
  output logic algRst,
  output logic [1:0] sramRdAlg,
  output logic [1:0] sramWrAlg,
  output logic [1:0] dmaRdBlocked,
  output logic [1:0] dmaWrBlocked,
  output logic [acr_pkg::NUM_GRP*acr_pkg::PHASE_W-1:0] dataGroupPhase,
  output logic [acr_pkg::PHASE_W-1:0] sramTxLeadPs
);
  import acr_pkg::*;

  localparam int PW = (ALG_DIV > 1) ? $clog2(ALG_DIV) : 1;
  localparam int HW = $clog2(CORE_HOLD + 1);
  localparam logic [PW-1:0] PH_LAST = PW'(ALG_DIV - 1);
  localparam logic [1:0] RST_LAST = 2'(ALG_RST_CYCLES - 1);

  // ---------------------------------------------
  // lock synchroniser and chip reset
  // ---------------------------------------------
  logic [NMGR-1:0] lockMeta;
  logic [NMGR-1:0] lockSync;
  logic allLocked;
  logic next_chipRst;
  logic [HW-1:0] holdCnt;
  logic [HW-1:0] next_holdCnt;
  logic next_coreRst;

  assign allLocked = &lockSync;

  always_comb begin
    // lock may drop at any time; no clean relation to clk_sys
    next_chipRst = ~allLocked;
    next_holdCnt = holdCnt;
    next_coreRst = coreRst;
    if (chipRst) begin
      next_holdCnt = HW'(CORE_HOLD);
      next_coreRst = 1'b1;
    end else if (holdCnt != '0) begin
      next_holdCnt = holdCnt - HW'(1);
    end else begin
      next_coreRst = 1'b0;
    end
  end

  // primary reset forces manager reset at once, without the clock
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      mgrReset <= 1'b1;
      lockMeta <= '0;
      lockSync <= '0;
      chipRst <= 1'b1;
      holdCnt <= HW'(CORE_HOLD);
      coreRst <= 1'b1;
    end else begin
      mgrReset <= 1'b0;
      lockMeta <= mgrLocked;
      lockSync <= lockMeta;
      chipRst <= next_chipRst;
      holdCnt <= next_holdCnt;
      coreRst <= next_coreRst;
    end
  end

  // ---------------------------------------------
  // algorithm clock phase
  // ---------------------------------------------
  // clk_sys is the undivided manager output, also its feedback
  // phase 0 marks a core edge that is also an alg clock edge
  logic [PW-1:0] phaseCnt;
  logic [PW-1:0] next_phaseCnt;
  logic edgeNow;

  assign edgeNow = (phaseCnt == '0);

  always_comb begin
    next_phaseCnt = phaseCnt;
    if (coreRst || phaseCnt == PH_LAST) begin
      next_phaseCnt = '0;
    end else begin
      next_phaseCnt = phaseCnt + PW'(1);
    end
  end

  // ---------------------------------------------
  // register port
  // ---------------------------------------------
  logic goPend;
  logic next_goPend;
  logic goAccept;
  logic goWrite;
  logic [DATA_W-1:0] next_regRdData;
  acr_state_e state;
  acr_state_e next_state;

  assign goWrite = regWrStb && regAddr == CONTROL_OFS && regWrData[CTRL_GO_BIT];

  always_comb begin
    next_regRdData = '0;
    if (regRdStb) begin
      if (regAddr == STATUS_OFS) begin
        next_regRdData[ST_ALGRST_BIT] = algRst;
        next_regRdData[ST_CLKEN_BIT] = algClkEnable;
        next_regRdData[ST_CORERST_BIT] = coreRst;
        next_regRdData[ST_LOCKED_BIT] = allLocked;
        next_regRdData[ST_PEND_BIT] = goPend;
        next_regRdData[ST_STATE_LSB +: 2] = state;
      end else if (regAddr == BUILD_OFS) begin
        next_regRdData[BLD_DIV_LSB +: 8] = 8'(ALG_DIV);
        next_regRdData[BLD_SRAM_LSB +: 4] = {SRAM_WR_EN, SRAM_RD_EN};
      end else begin
        next_regRdData = '0;
      end
    end
  end

  always_comb begin
    // a go written in the accept cycle stays pending: set wins
    next_goPend = goPend;
    if (coreRst) begin
      next_goPend = 1'b0;
    end else if (goWrite) begin
      next_goPend = 1'b1;
    end else if (goAccept) begin
      next_goPend = 1'b0;
    end
  end

  // ---------------------------------------------
  // algorithm controller
  // ---------------------------------------------
  logic [1:0] pulseCnt;
  logic [1:0] next_pulseCnt;
  logic next_algRst;
  logic next_algClkEnable;
  logic next_algClkTick;
  logic algActive;

  // go is only taken on an alg edge so reset rises on one
  assign goAccept = goPend && edgeNow && !coreRst;

  always_comb begin
    next_state = state;
    next_pulseCnt = pulseCnt;
    next_algRst = algRst;
    next_algClkEnable = algClkEnable;
    if (coreRst) begin
      next_state = ACR_HOLD;
      next_pulseCnt = '0;
      next_algRst = 1'b1;
      next_algClkEnable = 1'b0;
    end else if (edgeNow) begin
      case (state)
        ACR_HOLD: begin
          next_algRst = 1'b1;
          next_algClkEnable = 1'b0;
        end
        ACR_PULSE: begin
          if (pulseCnt == RST_LAST) begin
            next_state = ACR_RUN;
            next_algRst = 1'b0;
          end else begin
            next_pulseCnt = pulseCnt + 2'h1;
          end
        end
        ACR_RUN: begin
          if (algDone) begin
            next_state = ACR_DONE;
            next_algClkEnable = 1'b0;
          end
        end
        ACR_DONE: begin
          // reset stays low so alg state can be inspected
          next_algRst = 1'b0;
          next_algClkEnable = 1'b0;
        end
        default: begin
          next_state = ACR_HOLD;
        end
      endcase
      // a new go restarts from any state
      if (goAccept) begin
        next_state = ACR_PULSE;
        next_pulseCnt = '0;
        next_algRst = 1'b1;
        next_algClkEnable = 1'b1;
      end
    end
  end

  assign algActive = (state == ACR_PULSE) || (state == ACR_RUN);

  // tick marks the cycle just after a gated alg rising edge
  assign next_algClkTick = edgeNow && algClkEnable && !coreRst;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      phaseCnt <= '0;
      goPend <= 1'b0;
      regRdData <= '0;
      state <= ACR_HOLD;
      pulseCnt <= '0;
      algRst <= 1'b1;
      algClkEnable <= 1'b0;
      algClkTick <= 1'b0;
    end else begin
      phaseCnt <= next_phaseCnt;
      goPend <= next_goPend;
      regRdData <= next_regRdData;
      state <= next_state;
      pulseCnt <= next_pulseCnt;
      algRst <= next_algRst;
      algClkEnable <= next_algClkEnable;
      algClkTick <= next_algClkTick;
    end
  end

  // ---------------------------------------------
  // build-time routing and clock phases
  // ---------------------------------------------
  // only one ALG_DIV value exists, so exactly one rate is chosen
  logic [NUM_GRP*PHASE_W-1:0] grpPhase;

  always_comb begin
    grpPhase = '0;
    for (int g = 0; g < NUM_GRP; g++) begin
      grpPhase[g*PHASE_W +: PHASE_W] = PHASE_W'(g * GRP_SHIFT_PS);
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      algUseDivided <= 1'b0;
      sramRdAlg <= '0;
      sramWrAlg <= '0;
      dmaRdBlocked <= '0;
      dmaWrBlocked <= '0;
      dataGroupPhase <= '0;
      sramTxLeadPs <= '0;
    end else begin
      algUseDivided <= (ALG_DIV > 1);
      sramRdAlg <= SRAM_RD_EN;
      sramWrAlg <= SRAM_WR_EN;
      // dma loses an alg-enabled port only while the alg is in the pulse or run state
      dmaRdBlocked <= SRAM_RD_EN & {2{algActive}};
      dmaWrBlocked <= SRAM_WR_EN & {2{algActive}};
      dataGroupPhase <= grpPhase;
      sramTxLeadPs <= PHASE_W'(SRAM_TX_LEAD_PS);
    end
  end

  // ---------------------------------------------
  // checks
  // ---------------------------------------------
  logic [2:0] hEdges;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      hEdges <= '0;
    end else if (state != ACR_PULSE) begin
      hEdges <= '0;
    end else if (edgeNow) begin
      hEdges <= hEdges + 3'h1;
    end
  end

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  chk_tick_aligned: assert property (algClkTick |-> $past(phaseCnt) == '0)
    else $error("alg tick off a common edge");
  chk_rst_edge: assert property ($changed(algRst) && !$past(coreRst) |-> $past(phaseCnt) == '0)
    else $error("alg reset moved off an alg edge");
  chk_enable_edge: assert property ($changed(algClkEnable) && !$past(coreRst) |-> $past(phaseCnt) == '0)
    else $error("clock enable moved off an alg edge");
  chk_pulse_four: assert property ($fell(algRst) |-> $past(hEdges) == 3'h3 && state == ACR_RUN)
    else $error("alg reset pulse not four alg cycles");
  chk_unlock_reset: assert property (!allLocked |=> chipRst ##1 coreRst)
    else $error("unlock did not reset chip and core");
  chk_hold_first: assert property (state == ACR_HOLD && !$past(goAccept) |-> algRst && !algClkEnable)
    else $error("alg left reset before first go");
  chk_done_open: assert property (state == ACR_DONE |-> !algRst ##1 !algClkTick)
    else $error("done state reset or clocked");
  chk_go_start: assert property (goAccept && !coreRst |=> algRst && algClkEnable && state == ACR_PULSE)
    else $error("go did not start reset pulse");
  chk_dma_block: assert property (algActive |=> dmaRdBlocked == SRAM_RD_EN)
    else $error("dma not blocked while alg active");
  chk_mgr_reset: assert property ($fell(rst) |-> mgrReset)
    else $error("manager reset not held by primary reset");
endmodule : acr_alg_clock_reset

// ===== acr_alg_model.sv
// algorithm block model: raises done after a few gated ticks
// assumes tick marks each gated algorithm clock edge
`timescale 1ns/1ps
module acr_alg_model #(
  parameter int RUN_TICKS = 3
) (
  input wire logic clk_sys,
  input wire logic algClkTick,
  input wire logic algRst,
  output logic algDone
);
  int ticks;
  // state only moves on algorithm edges, reset held while algRst high
  always_ff @(posedge clk_sys) begin
    if (algRst) begin
      ticks <= 0;
      algDone <= 1'b0;
    end else if (algClkTick) begin
      ticks <= ticks + 1;
      if (ticks + 1 >= RUN_TICKS) begin
        algDone <= 1'b1;
      end
    end
  end
endmodule : acr_alg_model

// ===== acr_alg_clock_reset_tb.sv
// testbench for the algorithm clock and reset controller
// assumes ALG_DIV of 2 and the default sram enables
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin failures++; \
  $display("ERROR %s expected %0h seen %0h", nm, e, g); end end
module acr_alg_clock_reset_tb;
  import acr_pkg::*;
  localparam int DIV = 2;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic [1:0] mgrLocked = 2'h0;
  logic algDone;
  logic [7:0] regAddr = 8'h00;
  logic [31:0] regWrData = 32'h0;
  logic regWrStb = 1'b0;
  logic regRdStb = 1'b0;
  logic [31:0] regRdData, d;
  logic mgrReset, chipRst, coreRst, algClkEnable, algClkTick, algUseDivided, algRst;
  logic [1:0] sramRdAlg, sramWrAlg, dmaRdBlocked, dmaWrBlocked;
  logic [47:0] dataGroupPhase;
  logic [11:0] sramTxLeadPs;
  int failures = 0;
  int n_compared = 0;
  int n;
  int nTick;
  always #5 clk_sys = ~clk_sys;
  acr_alg_clock_reset #(.ALG_DIV(DIV)) i_acr_alg_clock_reset (.clk_sys(clk_sys), .rst(rst),
    .mgrLocked(mgrLocked), .algDone(algDone), .regAddr(regAddr), .regWrData(regWrData),
    .regWrStb(regWrStb), .regRdStb(regRdStb), .regRdData(regRdData), .mgrReset(mgrReset),
    .chipRst(chipRst), .coreRst(coreRst), .algClkEnable(algClkEnable), .algClkTick(algClkTick),
    .algUseDivided(algUseDivided), .algRst(algRst), .sramRdAlg(sramRdAlg), .sramWrAlg(sramWrAlg),
    .dmaRdBlocked(dmaRdBlocked), .dmaWrBlocked(dmaWrBlocked), .dataGroupPhase(dataGroupPhase),
    .sramTxLeadPs(sramTxLeadPs));
  acr_alg_model i_acr_alg_model (.clk_sys(clk_sys), .algClkTick(algClkTick), .algRst(algRst),
    .algDone(algDone));
  // ---------------------------------------------
  // register port access
  // ---------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk_sys);
    regWrStb <= 1'b1;
    regAddr <= a;
    regWrData <= v;
    @(posedge clk_sys);
    regWrStb <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge clk_sys);
    regRdStb <= 1'b1;
    regAddr <= a;
    @(posedge clk_sys);
    regRdStb <= 1'b0;
    #1 d = regRdData;
  endtask : rd
  task automatic close_out;
    $display("compared %0d mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : close_out
  // bounded wait on the reset level of the algorithm block
  task automatic wait_alg(input logic lvl);
    n = 0;
    while (algRst !== lvl && n < 60) begin
      @(posedge clk_sys);
      #1 n++;
    end
    if (algRst !== lvl) begin
      failures++;
      $display("ERROR algRst wait expected %0h seen %0h", lvl, algRst);
      close_out();
    end
  endtask : wait_alg
  // ---------------------------------------------
  // main sequence
  // ---------------------------------------------
  initial begin
    repeat (2) @(posedge clk_sys);
    #1;
    `CHK("mgrReset", 1'b1, mgrReset)
    `CHK("chipRst", 1'b1, chipRst)
    `CHK("coreRst", 1'b1, coreRst)
    @(posedge clk_sys);
    rst <= 1'b0;
    mgrLocked <= 2'h3;
    @(posedge clk_sys);
    #1 `CHK("mgrReset rel", 1'b0, mgrReset)
    repeat (4) @(posedge clk_sys);
    #1 `CHK("chipRst rel", 1'b0, chipRst)
    `CHK("coreRst hold", 1'b1, coreRst)
    repeat (CORE_RST_HOLD + 2) @(posedge clk_sys);
    #1 `CHK("coreRst rel", 1'b0, coreRst)
    `CHK("algRst held", 1'b1, algRst)
    `CHK("clk gated", 1'b0, algClkEnable)
    `CHK("divided", 1'b1, algUseDivided)
    `CHK("sram rd", 2'h1, sramRdAlg)
    `CHK("sram wr", 2'h2, sramWrAlg)
    `CHK("tx lead", 12'h4e2, sramTxLeadPs)
    for (int g = 0; g < NUM_GRP; g++) begin
      `CHK("grp phase", 12'(g * GRP_SHIFT_PS), dataGroupPhase[g*PHASE_W +: PHASE_W])
    end
    rd(BUILD_OFS);
    `CHK("build", 32'h0902, d)
    rd(8'h3c);
    `CHK("unmapped", 32'h0, d)
    // first go releases the held reset
    wr(CONTROL_OFS, 32'h1);
    wait_alg(1'b0);
    `CHK("clk running", 1'b1, algClkEnable)
    `CHK("dma rd blk", 2'h1, dmaRdBlocked)
    `CHK("dma wr blk", 2'h2, dmaWrBlocked)
    repeat (20) @(posedge clk_sys);
    rd(STATUS_OFS);
    `CHK("state done", 2'h3, d[9:8])
    `CHK("alg rst low", 1'b0, d[ST_ALGRST_BIT])
    `CHK("clk stopped", 1'b0, d[ST_CLKEN_BIT])
    `CHK("core rst bit", 1'b0, d[ST_CORERST_BIT])
    `CHK("locked bit", 1'b1, d[ST_LOCKED_BIT])
    `CHK("go pend bit", 1'b0, d[ST_PEND_BIT])
    `CHK("dma idle", 2'h0, dmaRdBlocked)
    `CHK("no tick", 1'b0, algClkTick)
    @(posedge clk_sys);
    #1 `CHK("rd data cleared", 32'h0, regRdData)
    // restart: pulse width in core cycles is four algorithm cycles
    wr(CONTROL_OFS, 32'h1);
    wait_alg(1'b1);
    n = 0;
    nTick = 0;
    while (algRst === 1'b1 && n < 60) begin
      @(posedge clk_sys);
      #1 n++;
      if (algClkTick === 1'b1) begin
        nTick++;
      end
    end
    `CHK("pulse cycles", ALG_RST_CYCLES * DIV, n)
    `CHK("pulse ticks", ALG_RST_CYCLES, nTick)
    // lock loss forces chip and core reset
    @(posedge clk_sys);
    mgrLocked <= 2'h1;
    repeat (5) @(posedge clk_sys);
    #1 `CHK("unlock chip", 1'b1, chipRst)
    `CHK("unlock core", 1'b1, coreRst)
    `CHK("unlock alg rst", 1'b1, algRst)
    `CHK("unlock gated", 1'b0, algClkEnable)
    close_out();
  end
endmodule : acr_alg_clock_reset_tb
